// ---- include/smbw_pkg.sv ----
package smbw_pkg;
  localparam logic [6:0] dev_addr      = 7'h6e;     // 0xdc with write bit
  localparam logic       dir_write     = 1'b0;
  localparam int         byte_w        = 8;
  localparam int         fifo_depth    = 8;
  localparam int         clk_mhz       = 10;
  localparam int         scl_khz       = 100;
  // scl half period in core_clk cycles
  localparam int         half_cycles   = (clk_mhz * 1000) / (2 * scl_khz);
  localparam logic [7:0] half_cnt      = 8'(half_cycles);
  localparam int         reg_count     = 256;
  localparam logic [3:0] bit_last      = 4'h7;
  localparam logic [3:0] bit_ack       = 4'h8;
  typedef logic [7:0] byte_t;
endpackage : smbw_pkg

// ---- include/smbw_if.sv ----
`timescale 1ns/1ps
interface smbw_if;
  logic scl_host;    // host drives clock (push-pull, low pulls)
  logic sda_host_oe; // host pulls data low while high
  logic sda_dev_oe;  // device pulls data low while high
  logic sda;
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport host   (output scl_host, output sda_host_oe, input sda);
  modport device (input scl_host, output sda_dev_oe, input sda);
endinterface : smbw_if

// ---- logic/smbw_fifo.sv ----
`timescale 1ns/1ps
module smbw_fifo #(
  parameter int width = 16,
  parameter int depth = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [width-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [width-1:0] out_data
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0]    wr_ptr;
  logic [aw-1:0]    rd_ptr;
  logic [aw:0]      fill;
  logic [aw-1:0]    next_wr_ptr;
  logic [aw-1:0]    next_rd_ptr;
  logic [aw:0]      next_fill;
  logic             push;
  logic             pop;

  // honest flags from occupancy count
  assign in_ready  = (fill != (aw+1)'(depth));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_wr_ptr = push ? aw'((wr_ptr + 1'b1) % depth) : wr_ptr;
    next_rd_ptr = pop ? aw'((rd_ptr + 1'b1) % depth) : rd_ptr;
    next_fill   = fill + (aw+1)'(push) - (aw+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  // storage has no reset; only valid entries are read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : smbw_fifo

// ---- logic/smbw_host.sv ----
`timescale 1ns/1ps
module smbw_host (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  smbw_if.host                   bus,
  input  wire logic              start_req,
  input  wire smbw_pkg::byte_t   start_index,
  input  wire smbw_pkg::byte_t   byte_count,
  input  wire logic              data_valid,
  output logic                   data_ready,
  input  wire smbw_pkg::byte_t   data_byte,
  output logic                   busy,
  output logic                   nack_seen
);
  typedef enum logic [2:0] {h_idle, h_start, h_bits, h_ack, h_stop, h_done} hstate_t;
  hstate_t         st, next_st;
  logic [7:0]      div, next_div;
  logic            ph, next_ph;      // 0 = scl low half, 1 = high half
  logic [3:0]      bitn, next_bitn;
  logic [1:0]      stage, next_stage; // 0 addr 1 index 2 count 3 data
  smbw_pkg::byte_t sh, next_sh;
  smbw_pkg::byte_t left, next_left;
  smbw_pkg::byte_t cnt_hold, next_cnt_hold;
  logic            scl, next_scl;
  logic            sda_oe, next_sda_oe;
  logic            nack, next_nack;
  logic            take;
  logic            sda_s1, sda_s2;
  logic            tick;

  assign tick = (div == smbw_pkg::half_cnt);
  assign bus.scl_host    = scl;
  assign bus.sda_host_oe = sda_oe;
  assign busy      = (st != h_idle);
  assign nack_seen = nack;
  // every data byte, the first included, is consumed only while it is offered
  assign take      = tick & ph & (st == h_ack) & stage[1] & ~sda_s2 & (left != '0)
                   & data_valid;
  assign data_ready = take;

  // line synchroniser
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  // bit-level sequencer
  always_comb begin
    next_st = st; next_div = tick ? 8'h00 : div + 8'h01; next_ph = ph;
    next_bitn = bitn; next_stage = stage; next_sh = sh; next_left = left;
    next_cnt_hold = cnt_hold; next_scl = scl; next_sda_oe = sda_oe; next_nack = nack;
    case (st)
      h_idle: begin
        next_div = 8'h00; next_scl = 1'b1; next_sda_oe = 1'b0;
        if (start_req) begin
          next_st = h_start; next_sda_oe = 1'b1; next_nack = 1'b0;
          next_sh = {smbw_pkg::dev_addr, smbw_pkg::dir_write};
          next_stage = 2'd0; next_bitn = 4'h0; next_ph = 1'b0;
          next_left = byte_count; next_cnt_hold = start_index;
        end
      end
      h_start: if (tick) begin
        next_scl = 1'b0; next_st = h_bits;
      end
      h_bits: if (tick) begin
        next_ph = ~ph;
        if (!ph) begin
          next_sda_oe = ~sh[7]; next_scl = 1'b1;
        end else begin
          next_scl = 1'b0; next_sh = {sh[6:0], 1'b0};
          if (bitn == smbw_pkg::bit_last) begin
            next_st = h_ack; next_bitn = 4'h0;
          end else next_bitn = bitn + 4'h1;
        end
      end
      h_ack: if (tick) begin
        next_ph = ~ph;
        if (!ph) begin
          next_sda_oe = 1'b0; next_scl = 1'b1;
        end else begin
          next_scl = 1'b0;
          if (sda_s2) begin
            next_nack = 1'b1; next_st = h_stop;
          end else if (stage == 2'd0) begin
            next_stage = 2'd1; next_sh = cnt_hold; next_st = h_bits;
          end else if (stage == 2'd1) begin
            next_stage = 2'd2; next_sh = left; next_st = h_bits;
          end else if (left == '0) begin
            next_st = h_stop;
          end else if (data_valid) begin
            next_stage = 2'd3; next_st = h_bits;
            next_sh = data_byte; next_left = left - 8'h01;
          end else next_st = h_stop;
        end
      end
      h_stop: if (tick) begin
        next_ph = ~ph;
        if (!ph) next_sda_oe = 1'b1;
        else begin
          next_scl = 1'b1; next_st = h_done;
        end
      end
      default: if (tick) begin
        next_sda_oe = 1'b0; next_st = h_idle; // data rises with clock high
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= h_idle; div <= 8'h00; ph <= 1'b0; bitn <= 4'h0; stage <= 2'd0;
      sh <= 8'h00; left <= 8'h00; cnt_hold <= 8'h00; scl <= 1'b1;
      sda_oe <= 1'b0; nack <= 1'b0;
    end else begin
      st <= next_st; div <= next_div; ph <= next_ph; bitn <= next_bitn;
      stage <= next_stage; sh <= next_sh; left <= next_left;
      cnt_hold <= next_cnt_hold; scl <= next_scl; sda_oe <= next_sda_oe;
      nack <= next_nack;
    end
  end
endmodule : smbw_host

// ---- logic/smbw_device.sv ----
`timescale 1ns/1ps
// Contract
// - start then address dc, device acknowledges
// - index byte acknowledged, sets first register
// - count byte follows, device acknowledges it
// - data stored at index n through n+x-1; a byte that meets a full buffer is acknowledged but dropped
// - each data byte acknowledged individually
// - host ends with stop after last
module smbw_device (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  smbw_if.device                 bus,
  output logic                   wr_valid,
  input  wire logic              wr_ready,
  output smbw_pkg::byte_t        wr_index,
  output smbw_pkg::byte_t        wr_data,
  output logic                   busy,
  output logic                   overrun
);
  typedef enum logic [2:0] {d_idle, d_addr, d_index, d_count, d_data, d_ack, d_ign} dstate_t;
  dstate_t         st;
  dstate_t         next_st;
  dstate_t         after;                // state to resume once the ack bit ends
  dstate_t         next_after;
  logic [2:0]      scl_p;                // [0],[1] sync, [2] history
  logic [2:0]      sda_p;
  logic            scl_r;
  logic            scl_f;
  logic            start_c;
  logic            stop_c;
  logic [3:0]      bitn;
  logic [3:0]      next_bitn;
  smbw_pkg::byte_t sh;
  smbw_pkg::byte_t next_sh;
  smbw_pkg::byte_t idx;
  smbw_pkg::byte_t next_idx;
  smbw_pkg::byte_t left;
  smbw_pkg::byte_t next_left;
  logic            ack_oe;
  logic            next_ack_oe;
  logic            ovr;
  logic            next_ovr;
  logic            push;
  logic            in_ready;

  // edge decode on a synchronised level [0] and its one-cycle history [1]
  function automatic logic went_high(input logic [1:0] s);
    return s[0] & ~s[1];
  endfunction : went_high

  function automatic logic went_low(input logic [1:0] s);
    return ~s[0] & s[1];
  endfunction : went_low

  // clock seen high on both the current and the previous sample
  function automatic logic held_high(input logic [1:0] s);
    return s[0] & s[1];
  endfunction : held_high

  // address byte that selects this target for a write
  function automatic logic own_write(input smbw_pkg::byte_t b);
    return b == {smbw_pkg::dev_addr, smbw_pkg::dir_write};
  endfunction : own_write

  // scl_p[1], sda_p[1] are the synchronised levels; only [1],[2] feed logic
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_p <= 3'h7;
      sda_p <= 3'h7;
    end else begin
      scl_p <= {scl_p[1:0], bus.scl_host};
      sda_p <= {sda_p[1:0], bus.sda};
    end
  end
  // start and stop are data edges while the clock stays high
  assign scl_r   = went_high(scl_p[2:1]);
  assign scl_f   = went_low(scl_p[2:1]);
  assign start_c = held_high(scl_p[2:1]) & went_low(sda_p[2:1]);
  assign stop_c  = held_high(scl_p[2:1]) & went_high(sda_p[2:1]);
  assign bus.sda_dev_oe = ack_oe;
  assign busy    = (st != d_idle);
  assign overrun = ovr;

  // byte engine; a full buffer is not stretched, the byte is dropped and flagged
  always_comb begin
    next_st     = st;
    next_after  = after;
    next_bitn   = bitn;
    next_sh     = sh;
    next_idx    = idx;
    next_left   = left;
    next_ack_oe = ack_oe;
    push        = 1'b0;
    if (start_c) begin
      // a repeated start restarts the address phase from any state
      next_st     = d_addr;
      next_bitn   = 4'h0;
      next_ack_oe = 1'b0;
    end else if (stop_c) begin
      next_st     = d_idle;
      next_ack_oe = 1'b0;
    end else begin
      // bits are taken on the rise, the ack is driven from the fall
      case (st)
        d_addr, d_index, d_count, d_data: begin
          if (scl_r) begin
            // shift msb first on the synchronised rise
            next_sh   = {sh[6:0], sda_p[1]};
            next_bitn = bitn + 4'h1;
          end else if (scl_f && bitn == smbw_pkg::bit_ack) begin
            next_bitn   = 4'h0;
            next_st     = d_ack;
            next_ack_oe = 1'b1;
            case (st)
              d_addr: begin
                if (own_write(sh)) begin
                  next_after = d_index;
                end else begin
                  next_st     = d_idle;
                  next_ack_oe = 1'b0;
                end
              end
              d_index: begin
                next_idx   = sh;
                next_after = d_count;
              end
              d_count: begin
                next_left  = sh;
                next_after = d_data;
              end
              default: begin
                if (left == '0) begin
                  // bytes beyond the count are left unacknowledged
                  next_st     = d_ign;
                  next_ack_oe = 1'b0;
                end else begin
                  push       = 1'b1;
                  next_idx   = idx + 8'h01;
                  next_left  = left - 8'h01;
                  next_after = d_data;
                end
              end
            endcase
          end
        end
        d_ack: begin
          // release on the fall that closes the acknowledge bit
          if (scl_f) begin
            next_ack_oe = 1'b0;
            next_st     = after;
          end
        end
        default: ;
      endcase
    end
  end

  // sticky overrun; reset only, so a single lost byte stays visible
  always_comb begin
    next_ovr = ovr | (push & ~in_ready);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ovr <= 1'b0;
    end else begin
      ovr <= next_ovr;
    end
  end

  // engine state registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st     <= d_idle;
      after  <= d_idle;
      bitn   <= 4'h0;
      sh     <= 8'h00;
      idx    <= 8'h00;
      left   <= 8'h00;
      ack_oe <= 1'b0;
    end else begin
      st     <= next_st;
      after  <= next_after;
      bitn   <= next_bitn;
      sh     <= next_sh;
      idx    <= next_idx;
      left   <= next_left;
      ack_oe <= next_ack_oe;
    end
  end

  // index and data travel together toward the register file
  // eight entries absorb a burst while the register side is slow
  smbw_fifo #(
    .width (2 * smbw_pkg::byte_w),
    .depth (smbw_pkg::fifo_depth)
  ) smbw_fifo_i (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   ({idx, sh}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_index, wr_data})
  );
endmodule : smbw_device

// ---- verif/smbw_asserts.sv ----
`timescale 1ns/1ps
module smbw_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_host,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic sda
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // framing edges: data moves while the clock stays high
  sequence start_seen;
    scl_host && $past(scl_host) && $fell(sda);
  endsequence
  sequence stop_seen;
    scl_host && $past(scl_host) && $rose(sda);
  endsequence
  sequence ack_begins;
    $rose(sda_dev_oe);
  endsequence

  a_start_by_host: assert property (
    start_seen |-> $rose(sda_host_oe)) else $error("start edge not made by host");
  a_host_released: assert property (
    scl_host && sda_dev_oe |-> !sda_host_oe) else $error("host drives during ack");
  a_ack_clocked: assert property (
    ack_begins |-> ##[40:60] $rose(scl_host)) else $error("ack not clocked by host");
  a_ack_holds: assert property (
    ack_begins |-> sda_dev_oe [*8]) else $error("ack pulse too short");
  a_ack_released: assert property (
    ack_begins |-> ##[95:105] $fell(sda_dev_oe)) else $error("ack not released in time");
  a_dev_low_phase: assert property (
    scl_host && $past(scl_host) |-> $stable(sda_dev_oe)) else $error("device moved sda at high");
  a_stop_by_host: assert property (
    stop_seen |-> $fell(sda_host_oe)) else $error("stop edge not made by host");
  a_stop_quiet: assert property (
    stop_seen |-> !sda_dev_oe [*8]) else $error("device active after stop");
endmodule : smbw_asserts

// ---- verif/smbus_block_write_target_tb_top.sv ----
`timescale 1ns/1ps
module smbus_block_write_target_tb_top;
  logic            core_clk;
  logic            rst_n;
  logic            start_req;
  smbw_pkg::byte_t start_index;
  smbw_pkg::byte_t byte_count;
  logic            data_valid;
  logic            data_ready;
  smbw_pkg::byte_t data_byte;
  logic            host_busy;
  logic            nack_seen;
  logic            wr_valid;
  logic            wr_ready;
  smbw_pkg::byte_t wr_index;
  smbw_pkg::byte_t wr_data;
  logic            dev_busy;
  logic            overrun;
  int              error_cnt;
  int              n_tests;
  int              cyc;
  logic [15:0]     got_q[$];

  smbw_if smbw_if_i ();
  smbw_host smbw_host_i (.core_clk(core_clk), .rst_n(rst_n), .bus(smbw_if_i),
    .start_req(start_req), .start_index(start_index), .byte_count(byte_count),
    .data_valid(data_valid), .data_ready(data_ready), .data_byte(data_byte),
    .busy(host_busy), .nack_seen(nack_seen));
  smbw_device smbw_device_i (.core_clk(core_clk), .rst_n(rst_n), .bus(smbw_if_i),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_index(wr_index), .wr_data(wr_data),
    .busy(dev_busy), .overrun(overrun));
  smbw_asserts smbw_asserts_i (.core_clk(core_clk), .rst_n(rst_n),
    .scl_host(smbw_if_i.scl_host), .sda_host_oe(smbw_if_i.sda_host_oe),
    .sda_dev_oe(smbw_if_i.sda_dev_oe), .sda(smbw_if_i.sda));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // collect handed-out words; the cycle ceiling covers about 65 bytes of traffic, over twice the 30 bytes sent
  always @(posedge core_clk) begin
    cyc++;
    if (rst_n && wr_valid && wr_ready) got_q.push_back({wr_index, wr_data});
    if (cyc == 60000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // payload derived from position, so a slip in order shows up
  function automatic smbw_pkg::byte_t pat(input smbw_pkg::byte_t j);
    return j * 8'h25 + 8'h1b;
  endfunction : pat

  // one block write; next byte is presented after each consumption pulse
  // v low offers no data, so the host must stop after the count byte
  task automatic write_block(input smbw_pkg::byte_t n, input smbw_pkg::byte_t x,
                             input logic v);
    smbw_pkg::byte_t k;
    logic            took;
    int              w;
    int              nt;
    k = 8'h00;
    took = 1'b0;
    w = 0;
    nt = 0;
    start_index = n;
    byte_count = x;
    data_byte = pat(8'h00);
    data_valid = v;
    start_req = 1'b1;
    @(negedge core_clk);
    start_req = 1'b0;
    while (host_busy === 1'b1 && w < 20000) begin
      @(negedge core_clk);
      if (took) begin
        k++;
        data_byte = pat(k);
      end
      took = data_ready;
      if (took) nt++;
      w++;
    end
    data_valid = 1'b0;
    repeat (10) @(negedge core_clk);
    check("host busy", 16'h0000, {15'h0000, host_busy});
    check("device busy", 16'h0000, {15'h0000, dev_busy});
    check("nack", 16'h0000, {15'h0000, nack_seen});
    check("bytes fed", v ? 16'(x) : 16'h0000, 16'(nt));
  endtask : write_block

  // compare stored words with the run n .. n+x-1
  task automatic expect_run(input smbw_pkg::byte_t n, input int x);
    logic [15:0] w;
    for (int j = 0; j < x; j++) begin
      w = (got_q.size() > 0) ? got_q.pop_front() : 16'hxxxx;
      check("index data", {8'(n + 8'(j)), pat(8'(j))}, w);
    end
    check("extra words", 16'h0000, 16'(got_q.size()));
  endtask : expect_run

  initial begin
    rst_n = 1'b0;
    start_req = 1'b0;
    start_index = 8'h00;
    byte_count = 8'h00;
    data_valid = 1'b0;
    data_byte = 8'h00;
    wr_ready = 1'b1;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    write_block(8'h10, 8'h03, 1'b1);
    expect_run(8'h10, 3);
    $display("test plain write done");
    write_block(8'hfe, 8'h03, 1'b1);
    expect_run(8'hfe, 3);
    $display("test index wrap done");
    write_block(8'h20, 8'h00, 1'b1);
    expect_run(8'h20, 0);
    $display("test empty count done");
    write_block(8'h30, 8'h02, 1'b0);
    expect_run(8'h30, 0);
    $display("test starved feed done");
    // stalled sink: eight words fit, the ninth is dropped yet still acknowledged
    wr_ready = 1'b0;
    write_block(8'h40, 8'h09, 1'b1);
    check("overrun", 16'h0001, {15'h0000, overrun});
    wr_ready = 1'b1;
    repeat (20) @(negedge core_clk);
    expect_run(8'h40, 8);
    $display("test full buffer done");
    complete_run();
  end
endmodule : smbus_block_write_target_tb_top
